/* design/pulse_irq_pkg.sv */
// Shared constants for the pulse measurement and input interrupt block.
// Assumes a single 50 MHz clock; all timing figures below derive from its period.
//
// How it works
// - Six channels on inputs one to six measure on-width, period and frequency.
// - Each enabled channel holds its latest width, period and frequency in hertz.
// - Width and period count whole microseconds by default.
// - Setting number 20 written with 1 makes channels one to four count 0.1 us.
// - Channels five and six stay in whole microseconds under the finer setting.
// - Defining a counter pair also enables measurement on both its inputs.
// - Enabling measurement alone never turns the sharing counter on.
// - Enabling measurement on a pair after its counter was defined disables that counter.
// - Width good to 10 kHz, frequency good to 20 kHz inputs.
// - Ten interrupt inputs: pins one to six and nine to twelve.
// - Each interrupt input triggers on rising or on falling edge.
// - A configured edge requests its handler at once, even if shorter than a scan.
// - A pin one to six made an interrupt loses counter and measurement use.
// - Pins nine to twelve are plain inputs or interrupts only.
// - Outside interrupts, inputs and outputs refresh only at the end of each scan.
// - Source 18 is a periodic timer firing every programmed number of milliseconds.
// - The periodic timer runs independent of the scan length.
// - Timer expiry preempts normal work but waits for a running handler.
// - Pins one to six may be counter and measurement at once; interrupts are exclusive.
`default_nettype none

package pulse_irq_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS         = 1000;
  localparam int TENTH_US_NS   = 100;
  localparam int MS_NS         = 1000000;
  localparam int COARSE_CYC    = US_NS / CLK_PERIOD_NS;
  localparam int FINE_CYC      = TENTH_US_NS / CLK_PERIOD_NS;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;

  localparam int NUM_PM_CH     = 6;
  localparam int NUM_FINE_CH   = 4;
  localparam int NUM_PAIRS     = 3;
  localparam int NUM_PINS      = 12;
  localparam int NUM_OUTS      = 16;
  localparam int SRC_W         = 5;
  localparam int SET_W         = 8;
  localparam int ARG_W         = 16;
  localparam int PRESC_W       = 8;

  localparam logic [SRC_W-1:0]    TIMER_SRC      = 5'h12;
  localparam logic [SRC_W-1:0]    PIN_SRC_BASE   = 5'h01;
  localparam logic [SET_W-1:0]    SET_RESOLUTION = 8'h14;
  localparam logic [ARG_W-1:0]    FINE_ON        = 16'h0001;
  localparam logic [NUM_PINS-1:0] IRQ_CAPABLE    = 12'hf3f;
  localparam logic [NUM_PINS-1:0] PM_PINS        = 12'h03f;
  localparam int                  EDGE_BIT       = 0;
endpackage : pulse_irq_pkg

`default_nettype wire

/* design/pulse_meter.sv */
// One pulse measurement channel: on-width, period and frequency of a pin.
// Assumes rise and fall arrive as clean one-cycle strobes from a synchronised pin.
`timescale 1ns/1ns
`default_nettype none

module pulse_meter
  import pulse_irq_pkg::*;
#(
  parameter int CW = 32
)
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          en,
  input  wire logic          fine,
  input  wire logic          rise,
  input  wire logic          fall,
  output logic [CW-1:0]      on_width_q,
  output logic [CW-1:0]      period_q,
  output logic [CW-1:0]      freq_q
);
  localparam int IDX_W = $clog2(CW);
  localparam logic [CW-1:0]      DIVIDEND = CW'(CLK_HZ);
  localparam logic [PRESC_W-1:0] FINE_LAST = PRESC_W'(FINE_CYC - 1);
  localparam logic [PRESC_W-1:0] COARSE_LAST = PRESC_W'(COARSE_CYC - 1);
  localparam logic [IDX_W-1:0]   IDX_TOP = IDX_W'(CW - 1);

  logic [PRESC_W-1:0] presc_q;
  logic [CW-1:0]      w_cnt_q;
  logic [CW-1:0]      p_cnt_q;
  logic [CW-1:0]      raw_q;
  logic               seen_rise_q;
  logic               div_busy_q;
  logic [IDX_W-1:0]   div_idx_q;
  logic [CW:0]        rem_q;
  logic [CW-1:0]      quo_q;
  logic [CW-1:0]      den_q;

  wire [PRESC_W-1:0] unit_last = fine ? FINE_LAST : COARSE_LAST;
  wire               tick      = (presc_q == unit_last);
  wire [CW:0]        rem_sh    = {rem_q[CW-1:0], DIVIDEND[div_idx_q]};
  wire               ge        = (rem_sh >= {1'b0, den_q});
  wire [CW:0]        rem_nx    = ge ? rem_sh - {1'b0, den_q} : rem_sh;
  wire [CW-1:0]      quo_nx    = {quo_q[CW-2:0], ge};
  wire [CW-1:0]      w_inc     = (&w_cnt_q) ? w_cnt_q : w_cnt_q + 1'b1;
  wire [CW-1:0]      p_inc     = (&p_cnt_q) ? p_cnt_q : p_cnt_q + 1'b1;
  wire [CW-1:0]      raw_inc   = (&raw_q) ? raw_q : raw_q + 1'b1;

  // Unit counters restart on every rising edge so width and period share one phase.
  always_ff @(posedge clk)
  begin
    if (!rstn || (ce && !en))
    begin
      presc_q     <= '0;
      w_cnt_q     <= '0;
      p_cnt_q     <= '0;
      raw_q       <= '0;
      seen_rise_q <= 1'b0;
      on_width_q  <= '0;
      period_q    <= '0;
    end
    else if (ce)
    begin
      if (rise)
      begin
        presc_q     <= '0;
        w_cnt_q     <= '0;
        p_cnt_q     <= '0;
        raw_q       <= '0;
        seen_rise_q <= 1'b1;
        if (seen_rise_q)
          period_q <= p_cnt_q;
      end
      else
      begin
        presc_q <= tick ? '0 : presc_q + 1'b1;
        p_cnt_q <= tick ? p_inc : p_cnt_q;
        w_cnt_q <= tick ? w_inc : w_cnt_q;
        raw_q   <= raw_inc;
        if (fall && seen_rise_q)
          on_width_q <= w_cnt_q;
      end
    end
  end

  // A serial divider turns the raw period into hertz; 32 cycles is far below
  // the shortest period the channel is asked to follow.
  always_ff @(posedge clk)
  begin
    if (!rstn || (ce && !en))
    begin
      div_busy_q <= 1'b0;
      div_idx_q  <= '0;
      rem_q      <= '0;
      quo_q      <= '0;
      den_q      <= '0;
      freq_q     <= '0;
    end
    else if (ce)
    begin
      if (rise && seen_rise_q)
      begin
        div_busy_q <= 1'b1;
        div_idx_q  <= IDX_TOP;
        rem_q      <= '0;
        quo_q      <= '0;
        den_q      <= raw_inc;
      end
      else if (div_busy_q)
      begin
        rem_q     <= rem_nx;
        quo_q     <= quo_nx;
        div_idx_q <= div_idx_q - 1'b1;
        if (div_idx_q == '0)
        begin
          div_busy_q <= 1'b0;
          freq_q     <= quo_nx;
        end
      end
    end
  end
endmodule : pulse_meter

`default_nettype wire

/* design/pulse_measure_and_input_irq.sv */
// Pulse measurement on six pins, edge interrupts on ten pins and a periodic
// millisecond tick, with handler dispatch and scan-time I/O refresh.
// Assumes command strobes are one cycle wide and synchronous to clk, and that
// the program acknowledges each handler with handler_done.
`timescale 1ns/1ns
`default_nettype none

module pulse_measure_and_input_irq
  import pulse_irq_pkg::*;
#(
  parameter int CW        = 32,
  parameter int MS_CYCLES = MS_CYC,
  parameter int MS_W      = 17
)
(
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  input  wire logic [NUM_PINS-1:0]           din,
  input  wire logic                          scan_refresh,
  input  wire logic [NUM_OUTS-1:0]           out_image,
  input  wire logic                          pulse_measure_enable_cmd,
  input  wire logic [NUM_PM_CH-1:0]          pm_channel_mask,
  input  wire logic                          counter_define_cmd,
  input  wire logic [NUM_PAIRS-1:0]          counter_pair_mask,
  input  wire logic                          interrupt_define_cmd,
  input  wire logic [SRC_W-1:0]              intr_source,
  input  wire logic [ARG_W-1:0]              intr_arg,
  input  wire logic                          system_setting_cmd,
  input  wire logic [SET_W-1:0]              setting_num,
  input  wire logic [ARG_W-1:0]              setting_value,
  input  wire logic                          handler_done,
  output logic [NUM_PM_CH-1:0][CW-1:0]       read_on_width,
  output logic [NUM_PM_CH-1:0][CW-1:0]       read_period,
  output logic [NUM_PM_CH-1:0][CW-1:0]       read_frequency,
  output logic [NUM_PM_CH-1:0]               pm_enabled_q,
  output logic [NUM_PAIRS-1:0]               quadrature_counter_en_q,
  output logic [NUM_PINS-1:0]                irq_assigned_q,
  output logic                               fine_res_q,
  output logic [NUM_PINS-1:0]                input_image_q,
  output logic [NUM_OUTS-1:0]                output_pins_q,
  output logic                               handler_start_q,
  output logic [SRC_W-1:0]                   handler_src_q,
  output logic                               handler_busy_q,
  output logic                               periodic_tick_interrupt_q
);
  localparam int PIN_IDX_W = $clog2(NUM_PINS);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);

  // Synchroniser and edge detection.
  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic [NUM_PINS-1:0] prev_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end
    else if (ce)
    begin
      sync1_q <= din;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire [NUM_PINS-1:0] rise_w = sync2_q & ~prev_q;
  wire [NUM_PINS-1:0] fall_w = ~sync2_q & prev_q;

  // Configuration state.
  logic [NUM_PINS-1:0]  edge_rise_q;
  logic [ARG_W-1:0]     tick_period_q;
  logic [NUM_PM_CH-1:0] pm_en_d;
  logic [NUM_PAIRS-1:0] cnt_en_d;
  logic [NUM_PINS-1:0]  irq_asg_d;
  logic [NUM_PINS-1:0]  edge_rise_d;

  wire                def_is_timer = interrupt_define_cmd && (intr_source == TIMER_SRC);
  wire [SRC_W-1:0]    pin_off      = intr_source - PIN_SRC_BASE;
  wire                src_in_range = (intr_source >= PIN_SRC_BASE) &&
                                     (pin_off < SRC_W'(NUM_PINS));
  wire [NUM_PINS-1:0] def_pin_onehot = src_in_range ?
                                       (NUM_PINS'(1) << pin_off[PIN_IDX_W-1:0]) : '0;
  wire [NUM_PINS-1:0] def_pin_mask = interrupt_define_cmd ?
                                     (def_pin_onehot & IRQ_CAPABLE) : '0;
  wire                def_rising   = intr_arg[EDGE_BIT];
  wire                set_fine_hit = system_setting_cmd && (setting_num == SET_RESOLUTION);

  // Commands in one cycle apply in order: counter define, measurement enable,
  // then interrupt define, so the latest kind of use of a pin wins.
  always_comb
  begin
    pm_en_d     = pm_enabled_q;
    cnt_en_d    = quadrature_counter_en_q;
    irq_asg_d   = irq_assigned_q;
    edge_rise_d = edge_rise_q;
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      if (counter_define_cmd && counter_pair_mask[p])
      begin
        cnt_en_d[p]       = 1'b1;
        pm_en_d[2*p]      = 1'b1;
        pm_en_d[2*p+1]    = 1'b1;
        irq_asg_d[2*p]    = 1'b0;
        irq_asg_d[2*p+1]  = 1'b0;
      end
      if (pulse_measure_enable_cmd && (pm_channel_mask[2*p] || pm_channel_mask[2*p+1]))
        cnt_en_d[p] = 1'b0;
      if (def_pin_mask[2*p] || def_pin_mask[2*p+1])
        cnt_en_d[p] = 1'b0;
    end
    if (pulse_measure_enable_cmd)
    begin
      pm_en_d   = pm_en_d | pm_channel_mask;
      irq_asg_d = irq_asg_d & ~(NUM_PINS'(pm_channel_mask));
    end
    pm_en_d     = pm_en_d & ~def_pin_mask[NUM_PM_CH-1:0];
    irq_asg_d   = irq_asg_d | def_pin_mask;
    edge_rise_d = (edge_rise_d & ~def_pin_mask) |
                  (def_pin_mask & {NUM_PINS{def_rising}});
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pm_enabled_q            <= '0;
      quadrature_counter_en_q <= '0;
      irq_assigned_q          <= '0;
      edge_rise_q             <= '0;
      fine_res_q              <= 1'b0;
      tick_period_q           <= '0;
    end
    else if (ce)
    begin
      pm_enabled_q            <= pm_en_d;
      quadrature_counter_en_q <= cnt_en_d;
      irq_assigned_q          <= irq_asg_d;
      edge_rise_q             <= edge_rise_d;
      if (set_fine_hit)
        fine_res_q <= (setting_value == FINE_ON);
      if (def_is_timer)
        tick_period_q <= intr_arg;
    end
  end

  // Measurement channels; only the first few may use the finer unit.
  for (genvar g = 0; g < NUM_PM_CH; g++)
  begin : g_meter
    localparam bit FINE_OK = (g < NUM_FINE_CH);
    pulse_meter #(
      .CW (CW)
    ) u_meter (
      .clk        (clk),
      .rstn       (rstn),
      .ce         (ce),
      .en         (pm_enabled_q[g] & ~irq_assigned_q[g]),
      .fine       (fine_res_q & FINE_OK),
      .rise       (rise_w[g]),
      .fall       (fall_w[g]),
      .on_width_q (read_on_width[g]),
      .period_q   (read_period[g]),
      .freq_q     (read_frequency[g])
    );
  end

  // Periodic tick, counted on clk alone so scan length cannot stretch it.
  logic [MS_W-1:0]  ms_presc_q;
  logic [ARG_W-1:0] ms_cnt_q;

  wire ms_tick      = (ms_presc_q == MS_LAST);
  wire tick_running = (tick_period_q != '0);
  wire tick_expire  = tick_running && ms_tick && (ms_cnt_q == tick_period_q - 1'b1);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ms_presc_q <= '0;
      ms_cnt_q   <= '0;
    end
    else if (ce)
    begin
      if (def_is_timer || !tick_running)
      begin
        ms_presc_q <= '0;
        ms_cnt_q   <= '0;
      end
      else
      begin
        ms_presc_q <= ms_tick ? '0 : ms_presc_q + 1'b1;
        if (ms_tick)
          ms_cnt_q <= tick_expire ? '0 : ms_cnt_q + 1'b1;
      end
    end
  end

  // Pending events and handler dispatch.
  logic [NUM_PINS-1:0]  pend_q;
  logic [PIN_IDX_W-1:0] pick_idx;
  logic                 pick_found;

  always_comb
  begin
    pick_idx   = '0;
    pick_found = 1'b0;
    for (int i = NUM_PINS - 1; i >= 0; i--)
    begin
      if (pend_q[i])
      begin
        pick_idx   = PIN_IDX_W'(i);
        pick_found = 1'b1;
      end
    end
  end

  wire [NUM_PINS-1:0] edge_hit  = irq_assigned_q &
                                  ((edge_rise_q & rise_w) | (~edge_rise_q & fall_w));
  wire                can_start = !handler_busy_q && !handler_start_q;
  wire                take_tmr  = can_start && periodic_tick_interrupt_q;
  wire                take_pin  = can_start && !periodic_tick_interrupt_q && pick_found;
  wire [NUM_PINS-1:0] taken_pin = take_pin ? (NUM_PINS'(1) << pick_idx) : '0;
  wire [SRC_W-1:0]    pin_src   = SRC_W'(pick_idx) + PIN_SRC_BASE;

  // A new event in the cycle its flag is taken sets the flag again.
  wire [NUM_PINS-1:0] pend_d    = (pend_q & ~taken_pin & irq_assigned_q) | edge_hit;
  wire                tmr_pnd_d = (periodic_tick_interrupt_q && !take_tmr && tick_running) ||
                                  tick_expire;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pend_q                    <= '0;
      periodic_tick_interrupt_q <= 1'b0;
      handler_start_q           <= 1'b0;
      handler_src_q             <= '0;
      handler_busy_q            <= 1'b0;
    end
    else if (ce)
    begin
      pend_q                    <= pend_d;
      periodic_tick_interrupt_q <= tmr_pnd_d;
      handler_start_q           <= take_tmr || take_pin;
      if (take_tmr)
        handler_src_q <= TIMER_SRC;
      else if (take_pin)
        handler_src_q <= pin_src;
      if (take_tmr || take_pin)
        handler_busy_q <= 1'b1;
      else if (handler_done)
        handler_busy_q <= 1'b0;
    end
  end

  // Scan-time I/O image: pins are seen by the program only at the refresh.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      input_image_q <= '0;
      output_pins_q <= '0;
    end
    else if (ce && scan_refresh)
    begin
      input_image_q <= sync2_q;
      output_pins_q <= out_image;
    end
  end
endmodule : pulse_measure_and_input_irq

`default_nettype wire

/* tb/pulse_irq_checker.sv */
// Concurrent checks on the ports of the pulse measurement and interrupt block.
// Assumes one clock domain and the synchronous active-low reset of the design.
`timescale 1ns/1ns
`default_nettype none

module pulse_irq_checker
  import pulse_irq_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 ce,
  input wire logic                 scan_refresh,
  input wire logic [NUM_OUTS-1:0]  out_image,
  input wire logic                 pulse_measure_enable_cmd,
  input wire logic [NUM_PM_CH-1:0] pm_channel_mask,
  input wire logic                 counter_define_cmd,
  input wire logic [NUM_PAIRS-1:0] counter_pair_mask,
  input wire logic                 interrupt_define_cmd,
  input wire logic                 system_setting_cmd,
  input wire logic [SET_W-1:0]     setting_num,
  input wire logic [ARG_W-1:0]     setting_value,
  input wire logic [NUM_PM_CH-1:0] pm_enabled_q,
  input wire logic [NUM_PAIRS-1:0] quadrature_counter_en_q,
  input wire logic [NUM_PINS-1:0]  irq_assigned_q,
  input wire logic                 fine_res_q,
  input wire logic [NUM_OUTS-1:0]  output_pins_q,
  input wire logic                 handler_start_q,
  input wire logic [SRC_W-1:0]     handler_src_q,
  input wire logic                 handler_busy_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_pm_enable_sets: assert property (
    ce && pulse_measure_enable_cmd && !interrupt_define_cmd
    |=> (pm_enabled_q & $past(pm_channel_mask)) == $past(pm_channel_mask))
    else $error("measurement enable did not set its channels");
  a_pair_sets_pm: assert property (
    ce && counter_define_cmd && counter_pair_mask[0] && !pulse_measure_enable_cmd
    && !interrupt_define_cmd |=> pm_enabled_q[1:0] == 2'h3 && quadrature_counter_en_q[0])
    else $error("counter define did not enable measurement on its pair");
  a_pm_no_counter: assert property (
    ce && pulse_measure_enable_cmd && !counter_define_cmd
    |=> (quadrature_counter_en_q & ~$past(quadrature_counter_en_q)) == 3'h0)
    else $error("measurement enable turned a counter on");
  a_pm_kills_counter: assert property (
    ce && pulse_measure_enable_cmd && pm_channel_mask[1:0] != 2'h0 && !counter_define_cmd
    |=> !quadrature_counter_en_q[0])
    else $error("measurement enable left the pair counter running");
  a_irq_exclusive: assert property (
    (irq_assigned_q[5:0] & pm_enabled_q) == 6'h0)
    else $error("pin is interrupt and measurement at once");
  a_irq_pins_only: assert property (
    (irq_assigned_q & ~IRQ_CAPABLE) == 12'h0)
    else $error("interrupt assigned to a pin without that function");
  a_start_single: assert property (
    handler_start_q |-> handler_busy_q ##1 !handler_start_q)
    else $error("handler start not a single pulse with busy");
  a_wait_busy: assert property (
    ce && handler_busy_q |=> !handler_start_q)
    else $error("handler started while another was running");
  a_src_assigned: assert property (
    handler_start_q |-> handler_src_q == TIMER_SRC || (handler_src_q >= 5'h1
    && handler_src_q <= 5'hc && irq_assigned_q[handler_src_q - 5'h1]))
    else $error("handler source is not an assigned interrupt");
  a_fine_setting: assert property (
    ce && system_setting_cmd && setting_num == SET_RESOLUTION
    |=> fine_res_q == ($past(setting_value) == FINE_ON))
    else $error("resolution setting not applied");
  a_refresh_out: assert property (
    ce && scan_refresh |=> output_pins_q == $past(out_image))
    else $error("outputs not refreshed from the image");
  a_out_hold: assert property (
    !scan_refresh |=> $stable(output_pins_q))
    else $error("outputs changed between refreshes");
endmodule : pulse_irq_checker

bind pulse_measure_and_input_irq pulse_irq_checker chk_u (.*);

`default_nettype wire

/* tb/pulse_source.sv */
// Rectangular pulse source standing in for an encoder or transducer.
// Assumes the bench keeps the rate under 20 kHz; the line rests low when stopped.
`timescale 1ns/1ns
`default_nettype none

module pulse_source
(
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] lo_cyc,
  output logic             pin_q
);
  logic [15:0] cnt_q;

  // Whole-cycle phases keep the expected width and period exact.
  always_ff @(posedge clk)
  begin
    if (!run)
    begin
      pin_q <= 1'b0;
      cnt_q <= 16'h1;
    end
    else if (cnt_q >= (pin_q ? hi_cyc : lo_cyc))
    begin
      pin_q <= !pin_q;
      cnt_q <= 16'h1;
    end
    else
      cnt_q <= cnt_q + 16'h1;
  end
endmodule : pulse_source

`default_nettype wire

/* tb/tb_pulse_measure_and_input_irq.sv */
// Self-checking bench for the pulse measurement and input interrupt block.
// Assumes the pulse source and the bound checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module tb_pulse_measure_and_input_irq
  import pulse_irq_pkg::*;
;
  localparam int MSC = 20;
  logic                       clk, rstn, ce, scan_refresh, handler_done, run, src_pin;
  logic                       pulse_measure_enable_cmd, counter_define_cmd;
  logic                       interrupt_define_cmd, system_setting_cmd;
  logic [NUM_PINS-1:0]        tb_din, irq_assigned_q, input_image_q;
  wire logic [NUM_PINS-1:0]   din;
  logic [NUM_OUTS-1:0]        out_image, output_pins_q;
  logic [NUM_PM_CH-1:0]       pm_channel_mask, pm_enabled_q;
  logic [NUM_PAIRS-1:0]       counter_pair_mask, quadrature_counter_en_q;
  logic [SRC_W-1:0]           intr_source, handler_src_q;
  logic [ARG_W-1:0]           intr_arg, setting_value;
  logic [SET_W-1:0]           setting_num;
  logic [NUM_PM_CH-1:0][31:0] read_on_width, read_period, read_frequency;
  logic                       fine_res_q, handler_start_q, handler_busy_q;
  logic                       periodic_tick_interrupt_q;
  int                         fail_count, cmp_count;

  // One source feeds pins 1 and 5 so both resolutions are seen on one train.
  assign din = tb_din | {7'h0, src_pin, 3'h0, src_pin};

  pulse_measure_and_input_irq #(.MS_CYCLES(MSC)) dut_u (.*);
  pulse_source src_u (.clk(clk), .run(run), .hi_cyc(16'h03f4), .lo_cyc(16'h05e7),
                      .pin_q(src_pin));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Kind 0 enables measurement, 1 defines counters, 2 defines an interrupt, 3 sets.
  task automatic cmd(input int k, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    pulse_measure_enable_cmd <= (k == 0);
    counter_define_cmd       <= (k == 1);
    interrupt_define_cmd     <= (k == 2);
    system_setting_cmd       <= (k == 3);
    pm_channel_mask          <= a[5:0];
    counter_pair_mask        <= a[2:0];
    intr_source              <= a[4:0];
    setting_num              <= a[7:0];
    intr_arg                 <= b;
    setting_value            <= b;
    @(posedge clk);
    pulse_measure_enable_cmd <= 1'b0;
    counter_define_cmd       <= 1'b0;
    interrupt_define_cmd     <= 1'b0;
    system_setting_cmd       <= 1'b0;
    #1;
  endtask : cmd

  task automatic wait_start(input logic [4:0] s, output int n);
    n = 0;
    while (handler_start_q !== 1'b1 && n < 300)
    begin
      step(1);
      n++;
    end
    if (n >= 300)
    begin
      fail_count++;
      print_verdict();
    end
    check(handler_src_q, s);
  endtask : wait_start

  task automatic ack();
    @(posedge clk);
    handler_done <= 1'b1;
    @(posedge clk);
    handler_done <= 1'b0;
    #1;
  endtask : ack

  task automatic chk_ch(input int i, input logic [31:0] w, input logic [31:0] p);
    check(read_on_width[i], w);
    check(read_period[i], p);
  endtask : chk_ch

  task automatic t_sharing();
    cmd(1, 16'h1, 16'h0);
    check({pm_enabled_q, quadrature_counter_en_q}, {6'h03, 3'h1});
    cmd(0, 16'h4, 16'h0);
    check({pm_enabled_q, quadrature_counter_en_q}, {6'h07, 3'h1});
    cmd(0, 16'h12, 16'h0);
    check({pm_enabled_q, quadrature_counter_en_q}, {6'h17, 3'h0});
    cmd(1, 16'h1, 16'h0);
    check({pm_enabled_q, quadrature_counter_en_q}, {6'h17, 3'h1});
  endtask : t_sharing

  // Train of 1012 high and 1511 low cycles: 20.24 us wide, 50.46 us period.
  task automatic t_measure();
    @(posedge clk);
    run <= 1'b1;
    step(3 * 2523);
    chk_ch(0, 32'h14, 32'h32);
    check(read_frequency[0], 32'h4d69);
    cmd(3, 16'h15, 16'h1);
    check(fine_res_q, 1'b0);
    cmd(3, 16'h14, 16'h1);
    check(fine_res_q, 1'b1);
    step(2 * 2523 + 100);
    chk_ch(0, 32'hca, 32'h1f8);
    chk_ch(4, 32'h14, 32'h32);
    check(read_frequency[4], 32'h4d69);
    @(posedge clk);
    run <= 1'b0;
  endtask : t_measure

  task automatic t_pin_irq();
    int n;
    cmd(2, 16'h3, 16'h0);
    check({pm_enabled_q[2], irq_assigned_q[2]}, 2'h1);
    cmd(2, 16'h9, 16'h1);
    cmd(2, 16'h7, 16'h1);
    check(irq_assigned_q, 12'h104);
    @(posedge clk);
    tb_din <= 12'h004;
    step(10);
    check(handler_busy_q, 1'b0);
    @(posedge clk);
    tb_din <= 12'h104;
    wait_start(5'h9, n);
    check(n, 4);
    // Two-cycle glitches while busy must stay pending, not be lost.
    @(posedge clk);
    tb_din <= 12'h000;
    step(1);
    @(posedge clk);
    tb_din <= 12'h104;
    step(10);
    ack();
    check(handler_busy_q, 1'b0);
    wait_start(5'h3, n);
    ack();
    wait_start(5'h9, n);
    ack();
    step(20);
    check(handler_busy_q, 1'b0);
  endtask : t_pin_irq

  task automatic t_refresh();
    @(posedge clk);
    out_image <= 16'ha5c3;
    tb_din    <= 12'h0c4;
    step(4);
    check(output_pins_q, 16'h0);
    @(posedge clk);
    scan_refresh <= 1'b1;
    @(posedge clk);
    scan_refresh <= 1'b0;
    out_image    <= 16'h0f0f;
    #1;
    check(output_pins_q, 16'ha5c3);
    check(input_image_q, 12'h0c4);
    step(5);
    check(output_pins_q, 16'ha5c3);
  endtask : t_refresh

  task automatic t_timer();
    int  n;
    time t0;
    cmd(2, 16'h12, 16'h2);
    wait_start(TIMER_SRC, n);
    t0 = $time;
    ack();
    wait_start(TIMER_SRC, n);
    check(($time - t0) / 20, 2 * MSC);
    ack();
    @(posedge clk);
    tb_din <= 12'h0c4;
    step(1);
    @(posedge clk);
    tb_din <= 12'h1c4;
    wait_start(5'h9, n);
    @(posedge clk);
    tb_din <= 12'h1c0;
    step(50);
    check(periodic_tick_interrupt_q, 1'b1);
    ack();
    wait_start(TIMER_SRC, n);
    check(n >= 1 && n <= 2, 1'b1);
    ack();
    wait_start(5'h3, n);
    ack();
  endtask : t_timer

  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    tb_din = 12'h0;
    out_image = 16'h0;
    scan_refresh = 1'b0;
    handler_done = 1'b0;
    run = 1'b0;
    {pulse_measure_enable_cmd, counter_define_cmd} = 2'h0;
    {interrupt_define_cmd, system_setting_cmd} = 2'h0;
    {pm_channel_mask, counter_pair_mask, intr_source, intr_arg} = 30'h0;
    {setting_num, setting_value} = 24'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    step(1);
    check({pm_enabled_q, irq_assigned_q, handler_busy_q, fine_res_q}, 32'h0);
    t_sharing();
    t_measure();
    t_pin_irq();
    t_refresh();
    t_timer();
    print_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule : tb_pulse_measure_and_input_irq

`default_nettype wire
